// ===== common/acfg_pkg.sv
// Constants for the converter mode-configuration register block.
// Assumes a 32-bit AXI4-Lite register port with word-aligned registers.
package acfg_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // ------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_FILTER_BIAS_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_GAIN_RATE_CONFIG = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_INPUT_SELECT = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_CONFIG_STATUS = 8'h20;

    localparam logic [ADDR_W-1:0] ADDR_FILTER_BIAS_CONFIG = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_GAIN_RATE_CONFIG = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_INPUT_SELECT = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_STATUS = 8'h80;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_FILTER_BIAS_CONFIG = 8'h80;
    localparam logic [REG_W-1:0] RST_GAIN_RATE_CONFIG = 8'h04;
    localparam logic [REG_W-1:0] RST_INPUT_SELECT = 8'h01;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FB_FILTER_LSB = 5;
    localparam int FB_BIAS_CONV_BIT = 4;
    localparam int FB_BIAS_DIR_BIT = 3;
    localparam int FB_BIAS_STR_LSB = 0;
    localparam int GR_BYPASS_BIT = 7;
    localparam int GR_GAIN_LSB = 4;
    localparam int GR_RATE_LSB = 0;
    localparam int IS_POS_LSB = 4;
    localparam int IS_NEG_LSB = 0;

    localparam int ST_FIR_RATE_BIT = 0;
    localparam int ST_FILTER_RSV_BIT = 1;
    localparam int ST_BIAS_RSV_BIT = 2;
    localparam int ST_GAIN_RSV_BIT = 3;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACFG_FLT_SINC1 = 3'b000,
        ACFG_FLT_SINC2 = 3'b001,
        ACFG_FLT_SINC3 = 3'b010,
        ACFG_FLT_SINC4 = 3'b011,
        ACFG_FLT_FIR = 3'b100
    } acfg_filter_e;

    localparam logic [2:0] BIAS_NONE = 3'h0;
    localparam logic [2:0] BIAS_CUR_MIN = 3'h1;
    localparam logic [2:0] BIAS_CUR_MAX = 3'h5;
    localparam logic [2:0] BIAS_RESISTOR = 3'h6;
    localparam logic [2:0] BIAS_RSV = 3'h7;

    localparam logic [2:0] GAIN_MAX = 3'h5;

    // Rate codes usable with the FIR filter: 2.5, 5, 10 and 20 samples/s
    localparam logic [3:0] RATE_2P5 = 4'h0;
    localparam logic [3:0] RATE_5 = 4'h1;
    localparam logic [3:0] RATE_10 = 4'h2;
    localparam logic [3:0] RATE_20 = 4'h4;

endpackage : acfg_pkg

// ===== common/acfg_reg_if.sv
// Register-access carrier between the bus slave and the register file.
// Assumes one clock; the slave drives requests, the register file answers.
`timescale 1ns/1ps
`default_nettype none

interface acfg_reg_if;
    import acfg_pkg::*;

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic rd_ok;

    modport bus (
        output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        input wr_ok, rd_data, rd_ok
    );

    modport regs (
        input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        output wr_ok, rd_data, rd_ok
    );

endinterface : acfg_reg_if

`default_nettype wire

// ===== hw/acfg_cfg_reg.sv
// One byte-wide configuration register with a fixed reset value.
// Assumes the write enable is already qualified by address and byte lane.
`timescale 1ns/1ps
`default_nettype none

module acfg_cfg_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    generate
        if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
            $error("acfg_cfg_reg: WIDTH must be 1 to 32");
        end
    endgenerate

    // Stores exactly what is written, reserved codes included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VALUE;
        end else if (we) begin
            q <= d;
        end
    end

endmodule : acfg_cfg_reg

`default_nettype wire

// ===== hw/acfg_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the register side answers decode and read data combinationally.
`timescale 1ns/1ps
`default_nettype none

module acfg_axil_slave
    import acfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    acfg_reg_if.bus rif
);

    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] aw_q;
    logic [DATA_W-1:0] w_q;
    logic [3:0] strb_q;
    logic do_write;

    // Ready stays low while a held item or an unanswered response is pending
    assign awready = !have_aw && !bvalid;
    assign wready = !have_w && !bvalid;
    assign arready = !rvalid;
    assign do_write = have_aw && have_w && !bvalid;

    assign rif.wr_en = do_write;
    assign rif.wr_addr = aw_q;
    assign rif.wr_data = w_q;
    assign rif.wr_strb = strb_q;
    assign rif.rd_addr = araddr;

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            have_aw <= 1'b0;
            aw_q <= '0;
        end else if (awvalid && awready) begin
            have_aw <= 1'b1;
            aw_q <= awaddr;
        end else if (do_write) begin
            have_aw <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            have_w <= 1'b0;
            w_q <= '0;
            strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            have_w <= 1'b1;
            w_q <= wdata;
            strb_q <= wstrb;
        end else if (do_write) begin
            have_w <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= rif.wr_ok ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channels
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rif.rd_ok ? rif.rd_data : '0;
            rresp <= rif.rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : acfg_axil_slave

`default_nettype wire

// ===== hw/acfg_top.sv
// Converter mode-configuration registers: filter, sensor bias, amplifier,
// output rate and input multiplexer settings behind an AXI4-Lite port.
// Assumes all inputs are synchronous to SYS_CLK (20 MHz).
//
// What this block does
// - Filter codes: sinc1-4, FIR default, 101-111 reserved
// - Bit 4 routes bias to primary/auxiliary converter
// - Bit 3 chooses bias pull direction
// - Bias strength: none, five currents, resistor, reserved
// - Gain-rate bit 7 bypasses the amplifier
// - Gain bits 6:4 select 1 to 32
// - Rate field: sixteen rates, default code 0100
// - FIR allows only 2.5, 5, 10, 20 rates; other rates are stored and flagged on FIR_RATE_INVALID
// - Gain-rate register at 05h, reset 04h
// - Input select register at 06h, reset 01h
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module acfg_top (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [acfg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [acfg_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [acfg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [acfg_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [2:0] FILTER_SELECT,
    output logic FIR_ACTIVE,
    output logic BIAS_CONVERTER_SELECT,
    output logic BIAS_DIRECTION,
    output logic [2:0] BIAS_STRENGTH,
    output logic BIAS_CURRENT_ON,
    output logic BIAS_RESISTOR_ON,
    output logic AMP_BYPASS,
    output logic [2:0] AMP_GAIN,
    output logic [3:0] OUTPUT_RATE_SELECT,
    output logic [3:0] INPUT_POS_SELECT,
    output logic [3:0] INPUT_NEG_SELECT,
    output logic FIR_RATE_INVALID,
    output logic RESERVED_CODE
);
    import acfg_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    acfg_reg_if rif ();

    // Hold the slave's combinational ready outputs reachable as plain ports
    logic awready_i;
    logic wready_i;
    logic arready_i;

    acfg_axil_slave u_slave (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(awready_i),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(wready_i),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(arready_i),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .rif(rif.bus)
    );

    // Readies are functions of slave flops only, so no input feeds them
    assign S_AXI_AWREADY = awready_i;
    assign S_AXI_WREADY = wready_i;
    assign S_AXI_ARREADY = arready_i;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic we_fb;
    logic we_gr;
    logic we_is;
    logic lane0;

    // Only byte lane 0 carries register data; other lanes are ignored
    assign lane0 = rif.wr_en && rif.wr_strb[0];

    always_comb begin
        we_fb = 1'b0;
        we_gr = 1'b0;
        we_is = 1'b0;
        rif.wr_ok = 1'b1;
        if (rif.wr_addr == ADDR_FILTER_BIAS_CONFIG) begin
            we_fb = lane0;
        end else if (rif.wr_addr == ADDR_GAIN_RATE_CONFIG) begin
            we_gr = lane0;
        end else if (rif.wr_addr == ADDR_INPUT_SELECT) begin
            we_is = lane0;
        end else if (rif.wr_addr == ADDR_CONFIG_STATUS) begin
            // Status is read-only; writes are dropped but answered OKAY
            rif.wr_ok = 1'b1;
        end else begin
            rif.wr_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [REG_W-1:0] filter_bias_config;
    logic [REG_W-1:0] gain_rate_config;
    logic [REG_W-1:0] input_select;
    logic [REG_W-1:0] config_status;

    acfg_cfg_reg #(
        .WIDTH(REG_W),
        .RESET_VALUE(RST_FILTER_BIAS_CONFIG)
    ) u_filter_bias (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .we(we_fb),
        .d(rif.wr_data[REG_W-1:0]),
        .q(filter_bias_config)
    );

    acfg_cfg_reg #(
        .WIDTH(REG_W),
        .RESET_VALUE(RST_GAIN_RATE_CONFIG)
    ) u_gain_rate (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .we(we_gr),
        .d(rif.wr_data[REG_W-1:0]),
        .q(gain_rate_config)
    );

    acfg_cfg_reg #(
        .WIDTH(REG_W),
        .RESET_VALUE(RST_INPUT_SELECT)
    ) u_input_select (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .we(we_is),
        .d(rif.wr_data[REG_W-1:0]),
        .q(input_select)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rif.rd_data = '0;
        rif.rd_ok = 1'b1;
        if (rif.rd_addr == ADDR_FILTER_BIAS_CONFIG) begin
            rif.rd_data[REG_W-1:0] = filter_bias_config;
        end else if (rif.rd_addr == ADDR_GAIN_RATE_CONFIG) begin
            rif.rd_data[REG_W-1:0] = gain_rate_config;
        end else if (rif.rd_addr == ADDR_INPUT_SELECT) begin
            rif.rd_data[REG_W-1:0] = input_select;
        end else if (rif.rd_addr == ADDR_CONFIG_STATUS) begin
            rif.rd_data[REG_W-1:0] = config_status;
        end else begin
            rif.rd_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    logic [2:0] filter_q;
    logic [2:0] strength_q;
    logic [2:0] gain_q;
    logic [3:0] rate_q;

    assign filter_q = filter_bias_config[FB_FILTER_LSB +: 3];
    assign strength_q = filter_bias_config[FB_BIAS_STR_LSB +: 3];
    assign gain_q = gain_rate_config[GR_GAIN_LSB +: 3];
    assign rate_q = gain_rate_config[GR_RATE_LSB +: 4];

    // ------------------------------------------------------------
    // Derived checks
    // ------------------------------------------------------------
    logic fir_sel;
    logic fir_rate_ok;
    logic filter_rsv;
    logic bias_rsv;
    logic gain_rsv;

    assign fir_sel = (filter_q == ACFG_FLT_FIR);
    assign filter_rsv = (filter_q > ACFG_FLT_FIR);
    assign bias_rsv = (strength_q == BIAS_RSV);
    assign gain_rsv = (gain_q > GAIN_MAX);
    // The device cannot refuse a bad pairing of two registers written apart,
    // so it flags it instead and leaves correction to software
    assign fir_rate_ok = (rate_q == RATE_2P5) || (rate_q == RATE_5)
                      || (rate_q == RATE_10) || (rate_q == RATE_20);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            config_status <= 8'h00;
        end else begin
            config_status <= 8'h00;
            config_status[ST_FIR_RATE_BIT] <= fir_sel && !fir_rate_ok;
            config_status[ST_FILTER_RSV_BIT] <= filter_rsv;
            config_status[ST_BIAS_RSV_BIT] <= bias_rsv;
            config_status[ST_GAIN_RSV_BIT] <= gain_rsv;
        end
    end

    // ------------------------------------------------------------
    // Converter control outputs
    // ------------------------------------------------------------
    // Field outputs are bits of the register flops themselves
    assign FILTER_SELECT = filter_q;
    assign BIAS_CONVERTER_SELECT = filter_bias_config[FB_BIAS_CONV_BIT];
    assign BIAS_DIRECTION = filter_bias_config[FB_BIAS_DIR_BIT];
    assign BIAS_STRENGTH = strength_q;
    assign AMP_BYPASS = gain_rate_config[GR_BYPASS_BIT];
    assign AMP_GAIN = gain_q;
    assign OUTPUT_RATE_SELECT = rate_q;
    assign INPUT_POS_SELECT = input_select[IS_POS_LSB +: 4];
    assign INPUT_NEG_SELECT = input_select[IS_NEG_LSB +: 4];

    // Decoded strobes lag the register by one cycle
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FIR_ACTIVE <= 1'b1;
            BIAS_CURRENT_ON <= 1'b0;
            BIAS_RESISTOR_ON <= 1'b0;
        end else begin
            FIR_ACTIVE <= fir_sel;
            BIAS_CURRENT_ON <= (strength_q >= BIAS_CUR_MIN)
                            && (strength_q <= BIAS_CUR_MAX);
            BIAS_RESISTOR_ON <= (strength_q == BIAS_RESISTOR);
        end
    end

    assign FIR_RATE_INVALID = config_status[ST_FIR_RATE_BIT];

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESERVED_CODE <= 1'b0;
        end else begin
            RESERVED_CODE <= filter_rsv || bias_rsv || gain_rsv;
        end
    end

endmodule : acfg_top

`default_nettype wire

// ===== test/acfg_top_properties.sv
// Concurrent checks on the ports of the configuration register block.
// Assumes one clock domain; bound to acfg_top below.
`timescale 1ns/1ps
`default_nettype none

module acfg_checker (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [acfg_pkg::DATA_W-1:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [2:0] FILTER_SELECT,
    input wire logic FIR_ACTIVE,
    input wire logic BIAS_CONVERTER_SELECT,
    input wire logic BIAS_DIRECTION,
    input wire logic [2:0] BIAS_STRENGTH,
    input wire logic BIAS_CURRENT_ON,
    input wire logic BIAS_RESISTOR_ON,
    input wire logic AMP_BYPASS,
    input wire logic [2:0] AMP_GAIN,
    input wire logic [3:0] OUTPUT_RATE_SELECT,
    input wire logic [3:0] INPUT_POS_SELECT,
    input wire logic [3:0] INPUT_NEG_SELECT,
    input wire logic FIR_RATE_INVALID,
    input wire logic RESERVED_CODE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence

    fir_flag_a: assert property (##1 FIR_ACTIVE == ($past(FILTER_SELECT) == 3'h4))
        else $error("fir flag wrong");
    bias_current_a: assert property (##1 BIAS_CURRENT_ON ==
        ($past(BIAS_STRENGTH) inside {[3'h1:3'h5]})) else $error("bias current wrong");
    bias_resistor_a: assert property (##1 BIAS_RESISTOR_ON ==
        ($past(BIAS_STRENGTH) == 3'h6)) else $error("bias resistor wrong");
    reserved_flag_a: assert property (##1 RESERVED_CODE == ($past(FILTER_SELECT) > 3'h4 ||
        $past(BIAS_STRENGTH) == 3'h7 || $past(AMP_GAIN) > 3'h5)) else $error("reserved wrong");
    fir_rate_a: assert property (##1 FIR_RATE_INVALID == ($past(FILTER_SELECT) == 3'h4 &&
        !($past(OUTPUT_RATE_SELECT) inside {4'h0, 4'h1, 4'h2, 4'h4})))
        else $error("fir rate wrong");
    write_answer_a: assert property (wr_taken |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("late bvalid");
    read_answer_a: assert property (rd_taken |=> S_AXI_RVALID)
        else $error("late rvalid");
    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bvalid dropped");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
    fields_quiet_a: assert property (!$rose(S_AXI_BVALID) |-> $stable({FILTER_SELECT,
        BIAS_CONVERTER_SELECT, BIAS_DIRECTION, BIAS_STRENGTH, AMP_BYPASS, AMP_GAIN,
        OUTPUT_RATE_SELECT, INPUT_POS_SELECT, INPUT_NEG_SELECT}))
        else $error("field moved unwritten");
    rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("rdata upper set");
endmodule : acfg_checker

bind acfg_top acfg_checker u_chk (.*);

`default_nettype wire

// ===== test/acfg_top_tb.sv
// Self-checking bench for the configuration registers.
// Assumes acfg_top and its bound checker; bench is bus master.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) compare(32'(g), 32'(e))

module acfg_top_tb;
    import acfg_pkg::*;

    logic SYS_CLK, RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB, OUTPUT_RATE_SELECT, INPUT_POS_SELECT, INPUT_NEG_SELECT;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [2:0] FILTER_SELECT, BIAS_STRENGTH, AMP_GAIN;
    logic FIR_ACTIVE, BIAS_CONVERTER_SELECT, BIAS_DIRECTION, BIAS_CURRENT_ON;
    logic BIAS_RESISTOR_ON, AMP_BYPASS, FIR_RATE_INVALID, RESERVED_CODE;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    acfg_top dut (.*);

    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    // ------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : compare

    task automatic complete_run;
        $display("compared %0d, mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Hang guard
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end

    task automatic settle;
        repeat (2) @(posedge SYS_CLK);
    endtask : settle

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r, input int stall);
        logic aw_done = 1'b0;
        logic w_done = 1'b0;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge SYS_CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_done = 1'b1;
                S_AXI_AWVALID <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_done = 1'b1;
                S_AXI_WVALID <= 1'b0;
            end
        end
        // Late bready on purpose
        repeat (stall) @(posedge SYS_CLK);
        S_AXI_BREADY <= 1'b1;
        do @(posedge SYS_CLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        `CHK(S_AXI_BRESP, r);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                          input int stall);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        repeat (stall) @(posedge SYS_CLK);
        S_AXI_RREADY <= 1'b1;
        do @(posedge SYS_CLK); while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        `CHK(S_AXI_RDATA, d);
        `CHK(S_AXI_RRESP, r);
    endtask : axi_rd

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        settle();
        `CHK({FILTER_SELECT, FIR_ACTIVE}, 4'h9);
        `CHK({BIAS_CONVERTER_SELECT, BIAS_DIRECTION}, 2'h0);
        `CHK({BIAS_STRENGTH, BIAS_CURRENT_ON, BIAS_RESISTOR_ON}, 5'h00);
        `CHK({AMP_BYPASS, AMP_GAIN, OUTPUT_RATE_SELECT}, 8'h04);
        `CHK({INPUT_POS_SELECT, INPUT_NEG_SELECT}, 8'h01);
        `CHK({FIR_RATE_INVALID, RESERVED_CODE}, 2'h0);
        axi_rd(ADDR_FILTER_BIAS_CONFIG, 32'h80, RESP_OKAY, 0);
        axi_rd(ADDR_GAIN_RATE_CONFIG, 32'h04, RESP_OKAY, 0);
        axi_rd(ADDR_INPUT_SELECT, 32'h01, RESP_OKAY, 0);
        axi_rd(ADDR_CONFIG_STATUS, 32'h00, RESP_OKAY, 0);
    endtask : t_defaults

    task automatic t_filter_codes;
        logic [2:0] f;
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            axi_wr(ADDR_FILTER_BIAS_CONFIG, {24'h0, f, 5'h00}, 4'hf, RESP_OKAY, i % 3);
            settle();
            `CHK(FILTER_SELECT, f);
            `CHK({FIR_ACTIVE, RESERVED_CODE}, {f == 3'h4, f > 3'h4});
            axi_rd(ADDR_FILTER_BIAS_CONFIG, {24'h0, f, 5'h00}, RESP_OKAY, i % 2);
        end
        axi_wr(ADDR_FILTER_BIAS_CONFIG, 32'h80, 4'hf, RESP_OKAY, 0);
    endtask : t_filter_codes

    task automatic t_bias_codes;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {3'h4, i[0], ~i[0], 3'(i)};
            axi_wr(ADDR_FILTER_BIAS_CONFIG, {24'h0, v}, 4'hf, RESP_OKAY, 0);
            settle();
            `CHK(BIAS_CONVERTER_SELECT, v[4]);
            `CHK(BIAS_DIRECTION, v[3]);
            `CHK(BIAS_STRENGTH, v[2:0]);
            `CHK({BIAS_CURRENT_ON, BIAS_RESISTOR_ON}, {i >= 1 && i <= 5, i == 6});
            axi_rd(ADDR_FILTER_BIAS_CONFIG, {24'h0, v}, RESP_OKAY, 0);
            axi_rd(ADDR_CONFIG_STATUS, {29'h0, i == 7, 2'h0}, RESP_OKAY, 0);
        end
        axi_wr(ADDR_FILTER_BIAS_CONFIG, 32'h80, 4'hf, RESP_OKAY, 0);
    endtask : t_bias_codes

    task automatic t_gain_rate_codes;
        logic [7:0] v;
        logic inv;
        for (int i = 0; i < 16; i++) begin
            v = {i[3], i[2:0], 4'(i)};
            inv = !(v[3:0] inside {RATE_2P5, RATE_5, RATE_10, RATE_20});
            axi_wr(ADDR_GAIN_RATE_CONFIG, {24'h0, v}, 4'hf, RESP_OKAY, 0);
            settle();
            `CHK(AMP_BYPASS, v[7]);
            `CHK(AMP_GAIN, v[6:4]);
            `CHK(OUTPUT_RATE_SELECT, v[3:0]);
            `CHK({FIR_RATE_INVALID, RESERVED_CODE}, {inv, v[6:4] > 3'h5});
            axi_rd(ADDR_GAIN_RATE_CONFIG, {24'h0, v}, RESP_OKAY, 0);
            axi_rd(ADDR_CONFIG_STATUS, {28'h0, v[6:4] > 3'h5, 2'h0, inv}, RESP_OKAY, 0);
        end
    endtask : t_gain_rate_codes

    task automatic t_misc;
        // Sinc4 with the rate left at 1111
        axi_wr(ADDR_FILTER_BIAS_CONFIG, 32'h60, 4'hf, RESP_OKAY, 0);
        settle();
        `CHK(FIR_RATE_INVALID, 1'b0);
        axi_wr(ADDR_INPUT_SELECT, 32'hffff_ff3a, 4'hf, RESP_OKAY, 1);
        axi_wr(ADDR_INPUT_SELECT, 32'h0000_00c5, 4'he, RESP_OKAY, 0);
        axi_wr(8'h1c, 32'h55, 4'hf, RESP_DECERR, 0);
        axi_wr(ADDR_CONFIG_STATUS, 32'hff, 4'hf, RESP_OKAY, 0);
        settle();
        `CHK({INPUT_POS_SELECT, INPUT_NEG_SELECT}, 8'h3a);
        axi_rd(ADDR_INPUT_SELECT, 32'h3a, RESP_OKAY, 2);
        axi_rd(8'h1c, 32'h0, RESP_DECERR, 0);
        axi_rd(ADDR_CONFIG_STATUS, 32'h08, RESP_OKAY, 0);
    endtask : t_misc

    task automatic t_mid_reset;
        RESET_N <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        @(posedge SYS_CLK);
        t_defaults();
    endtask : t_mid_reset

    initial begin
        RESET_N = 1'b0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
        repeat (12) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        @(posedge SYS_CLK);
        t_defaults();
        t_filter_codes();
        t_bias_codes();
        t_gain_rate_codes();
        t_misc();
        t_mid_reset();
        complete_run();
    end
endmodule : acfg_top_tb

`default_nettype wire
